// ### pia_control_line_logic.sv
// Purpose: Control lines, interrupt flags and request lines of two ports.
// Assumes: APB slave, one wait-free access phase; 40 MHz clock.
// Notes: Index 0 is port A, index 1 is port B.

module pia_control_line_logic (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Port A control lines
  input wire logic I_PORT_A_EDGE_INPUT,
  input wire logic I_PORT_A_DUAL_LINE,
  output logic O_PORT_A_DUAL_LINE,
  output logic O_PORT_A_DUAL_LINE_OE,
  output logic O_PORT_A_IRQ_N,
  output logic O_PORT_A_IRQ_OE,
  // Port B control lines
  input wire logic I_PORT_B_EDGE_INPUT,
  input wire logic I_PORT_B_DUAL_LINE,
  output logic O_PORT_B_DUAL_LINE,
  output logic O_PORT_B_DUAL_LINE_OE,
  output logic O_PORT_B_IRQ_N,
  output logic O_PORT_B_IRQ_OE,
  // Output latches
  output logic [7:0] O_PORT_A_OUTPUT_LATCH,
  output logic [7:0] O_PORT_B_OUTPUT_LATCH
);

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  function automatic pia_ctl_pkg::l2_mode_t l2_mode(input logic [7:0] ctrl);
    pia_ctl_pkg::l2_mode_t m;
    m = pia_ctl_pkg::L2_INPUT;
    if (ctrl[pia_ctl_pkg::B_L2_OUT]) begin
      if (ctrl[pia_ctl_pkg::B_L2_MODE4]) begin
        m = pia_ctl_pkg::L2_MANUAL;
      end else if (ctrl[pia_ctl_pkg::B_L2_LVL_EN]) begin
        m = pia_ctl_pkg::L2_PULSE;
      end else begin
        m = pia_ctl_pkg::L2_HANDSHAKE;
      end
    end
    return m;
  endfunction

  function automatic logic [4:0] reg_hit(input logic [7:0] addr);
    logic [4:0] h;
    h = 5'h00;
    case (addr)
      pia_ctl_pkg::OFF_CTRL_A: h = 5'h01;
      pia_ctl_pkg::OFF_CTRL_B: h = 5'h02;
      pia_ctl_pkg::OFF_DATA_A: h = 5'h04;
      pia_ctl_pkg::OFF_DATA_B: h = 5'h08;
      pia_ctl_pkg::OFF_LINES: h = 5'h10;
      default: h = 5'h00;
    endcase
    return h;
  endfunction

  // ----------------------------------------------------------------
  // Line sampling
  // ----------------------------------------------------------------
  logic [1:0] l1_in;
  logic [1:0] l2_in;
  logic [1:0] l1_lvl;
  logic [1:0] l1_rise;
  logic [1:0] l1_fall;
  logic [1:0] l2_lvl;
  logic [1:0] l2_rise;
  logic [1:0] l2_fall;

  assign l1_in = {I_PORT_B_EDGE_INPUT, I_PORT_A_EDGE_INPUT};
  assign l2_in = {I_PORT_B_DUAL_LINE, I_PORT_A_DUAL_LINE};

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  pia_ctl_pkg::apb_st_t st_q;
  pia_ctl_pkg::apb_st_t st_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [7:0] latch_q [2];
  logic [7:0] latch_d [2];
  logic [4:0] hit;
  logic done;
  logic [1:0] wr_ctrl;
  logic [1:0] rd_data;
  logic [1:0] trigger;
  logic [7:0] ctrl_q [2];
  logic flag1_q [2];
  logic flag2_q [2];
  logic [1:0] dual_q;
  logic [1:0] dual_oe_q;
  logic [1:0] irq_n_q;
  logic [1:0] irq_oe_q;

  assign hit = reg_hit(I_PADDR);
  assign done = (st_q == pia_ctl_pkg::ST_DONE) & I_PSEL & I_PENABLE;
  assign wr_ctrl = {2{done & I_PWRITE}} & hit[1:0];
  assign rd_data = {2{done & ~I_PWRITE}} & hit[3:2];
  // Port A line 2 reacts to data reads, port B line 2 to data writes.
  assign trigger = {done & I_PWRITE & hit[3], rd_data[0]};

  always_comb begin
    st_d = st_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    latch_d[0] = latch_q[0];
    latch_d[1] = latch_q[1];
    case (st_q)
      pia_ctl_pkg::ST_IDLE: begin
        if (I_PSEL && !I_PENABLE) begin
          st_d = pia_ctl_pkg::ST_DONE;
          pready_d = 1'b1;
          pslverr_d = (hit == 5'h00);
          prdata_d = 32'h0000_0000;
          if (!I_PWRITE) begin
            case (hit)
              5'h01: prdata_d[7:0] = {flag1_q[0], flag2_q[0], ctrl_q[0][5:0]};
              5'h02: prdata_d[7:0] = {flag1_q[1], flag2_q[1], ctrl_q[1][5:0]};
              5'h04: prdata_d[7:0] = latch_q[0];
              5'h08: prdata_d[7:0] = latch_q[1];
              5'h10: prdata_d[7:0] = {l1_lvl, l2_lvl, dual_q, irq_n_q};
              default: prdata_d[7:0] = 8'h00;
            endcase
          end
        end
      end
      pia_ctl_pkg::ST_DONE: begin
        if (done) begin
          st_d = pia_ctl_pkg::ST_IDLE;
          if (I_PWRITE && hit[2]) begin
            latch_d[0] = I_PWDATA[7:0];
          end
          if (I_PWRITE && hit[3]) begin
            latch_d[1] = I_PWDATA[7:0];
          end
        end else begin
          pready_d = pready_q;
          pslverr_d = pslverr_q;
        end
      end
      default: begin
        st_d = pia_ctl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      st_q <= pia_ctl_pkg::ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      latch_q[0] <= pia_ctl_pkg::LATCH_RESET;
      latch_q[1] <= pia_ctl_pkg::LATCH_RESET;
    end else begin
      st_q <= st_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      latch_q[0] <= latch_d[0];
      latch_q[1] <= latch_d[1];
    end
  end

  // ----------------------------------------------------------------
  // Per-port control line logic
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] ctrl_d;
    logic flag1_d;
    logic flag2_d;
    logic hs_q;
    logic hs_d;
    logic strobe_d;
    logic e1;
    logic e2;
    logic dual_d;
    logic dual_oe_d;
    logic irq_n_d;
    logic irq_oe_d;
    pia_ctl_pkg::l2_mode_t mode_q;
    pia_ctl_pkg::l2_mode_t mode_d;

    pia_line_sampler u_l1 (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_line(l1_in[p]),
      .o_level(l1_lvl[p]),
      .o_rise(l1_rise[p]),
      .o_fall(l1_fall[p])
    );

    pia_line_sampler u_l2 (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_line(l2_in[p]),
      .o_level(l2_lvl[p]),
      .o_rise(l2_rise[p]),
      .o_fall(l2_fall[p])
    );

    assign mode_q = l2_mode(ctrl_q[p]);
    assign mode_d = l2_mode(ctrl_d);
    assign e1 = ctrl_q[p][pia_ctl_pkg::B_EDGE1_RISE] ? l1_rise[p] : l1_fall[p];
    assign e2 = ctrl_q[p][pia_ctl_pkg::B_L2_MODE4] ? l2_rise[p] : l2_fall[p];

    always_comb begin
      ctrl_d = ctrl_q[p];
      if (wr_ctrl[p]) begin
        ctrl_d = I_PWDATA[7:0] & pia_ctl_pkg::CTRL_WMASK;
      end
      // Flags set on edges whatever the enables; a set beats a clearing read.
      flag1_d = (flag1_q[p] & ~rd_data[p]) | e1;
      flag2_d = (flag2_q[p] & ~rd_data[p]) | (e2 & (mode_q == pia_ctl_pkg::L2_INPUT));
      hs_d = 1'b1;
      if (mode_q == pia_ctl_pkg::L2_HANDSHAKE) begin
        hs_d = hs_q;
        if (trigger[p]) begin
          hs_d = 1'b0;
        end
        if (e1) begin
          hs_d = 1'b1;
        end
      end
      strobe_d = trigger[p] & (mode_q == pia_ctl_pkg::L2_PULSE);
      dual_oe_d = ctrl_d[pia_ctl_pkg::B_L2_OUT];
      case (mode_d)
        pia_ctl_pkg::L2_HANDSHAKE: dual_d = hs_d;
        pia_ctl_pkg::L2_PULSE: dual_d = ~strobe_d;
        pia_ctl_pkg::L2_MANUAL: dual_d = ctrl_d[pia_ctl_pkg::B_L2_LVL_EN];
        default: dual_d = 1'b1;
      endcase
      irq_n_d = ~((flag1_d & ctrl_d[pia_ctl_pkg::B_IRQ1_EN])
        | (flag2_d & ctrl_d[pia_ctl_pkg::B_L2_LVL_EN] & ~ctrl_d[pia_ctl_pkg::B_L2_OUT]));
      irq_oe_d = ~irq_n_d;
    end

    always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
        ctrl_q[p] <= pia_ctl_pkg::CTRL_RESET;
        flag1_q[p] <= 1'b0;
        flag2_q[p] <= 1'b0;
        hs_q <= 1'b1;
        dual_q[p] <= 1'b1;
        dual_oe_q[p] <= 1'b0;
        irq_n_q[p] <= 1'b1;
        irq_oe_q[p] <= 1'b0;
      end else begin
        ctrl_q[p] <= ctrl_d;
        flag1_q[p] <= flag1_d;
        flag2_q[p] <= flag2_d;
        hs_q <= hs_d;
        dual_q[p] <= dual_d;
        dual_oe_q[p] <= dual_oe_d;
        irq_n_q[p] <= irq_n_d;
        irq_oe_q[p] <= irq_oe_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_PORT_A_DUAL_LINE = dual_q[0];
  assign O_PORT_A_DUAL_LINE_OE = dual_oe_q[0];
  assign O_PORT_A_IRQ_N = irq_n_q[0];
  assign O_PORT_A_IRQ_OE = irq_oe_q[0];
  assign O_PORT_B_DUAL_LINE = dual_q[1];
  assign O_PORT_B_DUAL_LINE_OE = dual_oe_q[1];
  assign O_PORT_B_IRQ_N = irq_n_q[1];
  assign O_PORT_B_IRQ_OE = irq_oe_q[1];
  assign O_PORT_A_OUTPUT_LATCH = latch_q[0];
  assign O_PORT_B_OUTPUT_LATCH = latch_q[1];

endmodule // pia_control_line_logic

// ### pia_ctl_pkg.sv
// Purpose: Shared constants and types for the control-line and interrupt-flag logic.
// Assumes: APB slave with 32-bit data, one 40 MHz clock, synchronous active-low reset.
// Notes: Register offsets are byte addresses of aligned words.
//
// How it works
// - Port A line 1 edge sets flag bit 7.
// - Control bit 1 picks falling or rising edge.
// - Falling is high-to-low, rising is low-to-high.
// - Bit 7 with bit 0 pulls request low.
// - Bit 7 sets regardless of enable bit.
// - Bit 5 zero: line 2 input sets bit 6.
// - Bit 4 picks edge, bit 3 enables request.
// - Bit 6 sets regardless of enable bits.
// - Bit 5 one: line 2 is an output.
// - Port A pulse mode strobes on data read.
// - Port A handshake drives line 2 low on read.
// - Manual mode: line 2 follows bit 3.
// - Port B line 1 sets its bit 7.
// - Port B line 2 inputs behave like port A.
// - Port B pulse strobes on data write.
// - Port B handshake keyed to data writes.
// - Strobe holds line 2 low one cycle.
// - Port A handshake: line 1 edge drives high.
// - Port B handshake: write low, edge high.
// - Data register read clears both flags.

package pia_ctl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_DATA_A = 8'h08;
  localparam logic [7:0] OFF_DATA_B = 8'h0c;
  localparam logic [7:0] OFF_LINES = 8'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned B_IRQ1_EN = 0;
  localparam int unsigned B_EDGE1_RISE = 1;
  localparam int unsigned B_L2_LVL_EN = 3;
  localparam int unsigned B_L2_MODE4 = 4;
  localparam int unsigned B_L2_OUT = 5;
  localparam int unsigned B_FLAG2 = 6;
  localparam int unsigned B_FLAG1 = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h3f;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } apb_st_t;

  typedef enum logic [3:0] {
    L2_INPUT = 4'b0001,
    L2_HANDSHAKE = 4'b0010,
    L2_PULSE = 4'b0100,
    L2_MANUAL = 4'b1000
  } l2_mode_t;

endpackage

// ### pia_line_sampler.sv
// Purpose: Two-flop synchroniser and edge detector for one control line.
// Assumes: Line is asynchronous to I_CLK.
// Notes: Edges come from the second and third samples only.

module pia_line_sampler (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Line
  input wire logic i_line,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  always_comb begin
    meta_d = i_line;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;

endmodule // pia_line_sampler

// ### pia_ctl_asserts.sv
// Purpose: Checker for bus answers, request lines and line 2 drive.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Port A lines are watched here; port B is left to the bench.
module pia_ctl_asserts (
  // Clock, reset and bus
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Port A lines
  input wire logic I_PORT_A_EDGE_INPUT,
  input wire logic I_PORT_A_DUAL_LINE,
  input wire logic O_PORT_A_DUAL_LINE,
  input wire logic O_PORT_A_DUAL_LINE_OE,
  input wire logic O_PORT_A_IRQ_N,
  input wire logic O_PORT_A_IRQ_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [1:0] prev_q;
  logic [2:0] quiet_q;
  logic setup, done, bad, rd_a, wr_ca;
  assign setup = I_PSEL && !I_PENABLE;
  assign done = I_PSEL && I_PENABLE && O_PREADY;
  assign bad = I_PADDR > 8'h10 || I_PADDR[1:0] != 2'b00;
  assign rd_a = done && !I_PWRITE && I_PADDR == pia_ctl_pkg::OFF_DATA_A;
  assign wr_ca = done && I_PWRITE && I_PADDR == pia_ctl_pkg::OFF_CTRL_A;
  // Counts cycles since a port A input last moved.
  always_ff @(posedge I_CLK) begin
    prev_q <= {I_PORT_A_EDGE_INPUT, I_PORT_A_DUAL_LINE};
    if (!I_NRST) begin
      quiet_q <= 3'h0;
    end else if (prev_q != {I_PORT_A_EDGE_INPUT, I_PORT_A_DUAL_LINE}) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  property p_rst; $rose(I_NRST) |-> O_PORT_A_IRQ_N && !O_PORT_A_DUAL_LINE_OE; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_ready; setup |=> O_PREADY && O_PSLVERR == $past(bad); endproperty
  a_ready: assert property (p_ready) else $error("bad bus answer");
  property p_one; O_PREADY |=> !O_PREADY; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_oe; wr_ca |=> O_PORT_A_DUAL_LINE_OE == $past(I_PWDATA[5]); endproperty
  a_oe: assert property (p_oe) else $error("line 2 enable wrong");
  property p_man; wr_ca && I_PWDATA[5:4] == 2'b11 |=> O_PORT_A_DUAL_LINE == $past(I_PWDATA[3]);
  endproperty
  a_man: assert property (p_man) else $error("manual level wrong");
  property p_clr; rd_a && quiet_q > 3'h4 |=> O_PORT_A_IRQ_N; endproperty
  a_clr: assert property (p_clr) else $error("request not released");
  property p_oc; O_PORT_A_IRQ_OE == !O_PORT_A_IRQ_N; endproperty
  a_oc: assert property (p_oc) else $error("request drive wrong");
  property p_idle; !O_PORT_A_DUAL_LINE_OE |-> O_PORT_A_DUAL_LINE; endproperty
  a_idle: assert property (p_idle) else $error("line 2 low while input");
  property p_fall; $fell(O_PORT_A_DUAL_LINE) |-> $past(rd_a) || $past(wr_ca); endproperty
  a_fall: assert property (p_fall) else $error("line 2 fell uncaused");
  c_rd: cover property (rd_a);
  c_fall: cover property ($fell(O_PORT_A_DUAL_LINE));
  c_irq: cover property ($fell(O_PORT_A_IRQ_N));
endmodule // pia_ctl_asserts

bind pia_control_line_logic pia_ctl_asserts chk_u (.I_CLK, .I_NRST, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR, .I_PORT_A_EDGE_INPUT,
  .I_PORT_A_DUAL_LINE, .O_PORT_A_DUAL_LINE, .O_PORT_A_DUAL_LINE_OE, .O_PORT_A_IRQ_N,
  .O_PORT_A_IRQ_OE);

// ### pia_periph_model.sv
// Purpose: Peripheral on the far side of the control lines.
// Assumes: Bench sets idle levels; the handshake answer is automatic.
// Notes: Index 0 is port A, index 1 is port B.
module pia_periph_model (
  // Clock
  input wire logic i_clk,
  // Bench levels and handshake enables
  input wire logic [3:0] i_lvl,
  input wire logic [1:0] i_auto,
  // Line 2 pin levels
  input wire logic [1:0] i_dual,
  // Driven lines
  output logic [1:0] o_edge,
  output logic [1:0] o_dual
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_a_q = 4'h0;
  logic [3:0] wait_b_q = 4'h0;
  // Answers four cycles after line 2 goes low, never before.
  always_ff @(posedge i_clk) begin
    wait_a_q <= {wait_a_q[2:0], !i_dual[0]};
    wait_b_q <= {wait_b_q[2:0], !i_dual[1]};
  end
  assign o_edge = {i_auto[1] ? wait_b_q[3] : i_lvl[2], i_auto[0] ? wait_a_q[3] : i_lvl[0]};
  assign o_dual = {i_lvl[3], i_lvl[1]};
endmodule // pia_periph_model

// ### pia_control_line_logic_tb.sv
// Purpose: Self-checking bench for the control-line logic.
// Assumes: APB master tasks; the peripheral model drives the lines.
// Notes: Index 0 is port A, index 1 is port B.
module pia_control_line_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, c, ca, da, latch_a, latch_b;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] lvl;
  logic [1:0] auto, edge_l, mdual, pin, dout, oe, irqn, irq_oe;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int k;
  assign pin = {oe[1] ? dout[1] : mdual[1], oe[0] ? dout[0] : mdual[0]};
  initial begin
    forever #12.5 clk = ~clk;
  end
  pia_control_line_logic dut_u (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_PORT_A_EDGE_INPUT(edge_l[0]), .I_PORT_A_DUAL_LINE(pin[0]),
    .O_PORT_A_DUAL_LINE(dout[0]), .O_PORT_A_DUAL_LINE_OE(oe[0]), .O_PORT_A_IRQ_N(irqn[0]),
    .O_PORT_A_IRQ_OE(irq_oe[0]), .I_PORT_B_EDGE_INPUT(edge_l[1]), .I_PORT_B_DUAL_LINE(pin[1]),
    .O_PORT_B_DUAL_LINE(dout[1]), .O_PORT_B_DUAL_LINE_OE(oe[1]), .O_PORT_B_IRQ_N(irqn[1]),
    .O_PORT_B_IRQ_OE(irq_oe[1]), .O_PORT_A_OUTPUT_LATCH(latch_a),
    .O_PORT_B_OUTPUT_LATCH(latch_b));
  pia_periph_model model_u (.i_clk(clk), .i_lvl(lvl), .i_auto(auto), .i_dual(pin),
    .o_edge(edge_l), .o_dual(mdual));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; lvl = 4'hf; auto = 2'b00;
    pause(6);
    nrst <= 1'b1;
    apb(0, pia_ctl_pkg::OFF_CTRL_A, 0); chk(rd, 0);
    apb(0, pia_ctl_pkg::OFF_CTRL_B, 0); chk(rd, 0);
    chk(irqn, 2'b11);
    chk(irq_oe, 2'b00);
    apb(0, pia_ctl_pkg::OFF_LINES, 0); chk(rd, 32'hff);
    apb(1, pia_ctl_pkg::OFF_CTRL_A, 32'hff); apb(0, pia_ctl_pkg::OFF_CTRL_A, 0);
    chk(rd, 32'h3f);
    apb(0, 8'h14, 0); chk(er, 1); chk(rd, 0);
    $display("test registers done");
    for (int p = 0; p < 2; p++) for (int l = 0; l < 2; l++)
      for (int r = 0; r < 2; r++) for (int e = 0; e < 2; e++) begin
        ca = p ? pia_ctl_pkg::OFF_CTRL_B : pia_ctl_pkg::OFF_CTRL_A;
        da = p ? pia_ctl_pkg::OFF_DATA_B : pia_ctl_pkg::OFF_DATA_A;
        c = l ? 8'(r * 16 + e * 8) : 8'(r * 2 + e);
        lvl[2 * p + l] <= !r;
        pause(6); apb(1, ca, c); apb(0, da, 0);
        lvl[2 * p + l] <= r[0];
        pause(6); apb(0, ca, 0);
        chk(rd, c | (l ? 8'h40 : 8'h80));
        chk(irqn[p], !e);
        chk(irq_oe[p], e);
        apb(0, da, 0); apb(0, ca, 0); chk(rd, c);
        chk(irqn[p], 1);
        chk(irq_oe[p], 0);
        lvl[2 * p + l] <= !r;
        pause(6); apb(0, ca, 0); chk(rd, c);
      end
    lvl <= 4'hf;
    pause(6);
    $display("test edge inputs done");
    for (int p = 0; p < 2; p++) begin
      ca = p ? pia_ctl_pkg::OFF_CTRL_B : pia_ctl_pkg::OFF_CTRL_A;
      da = p ? pia_ctl_pkg::OFF_DATA_B : pia_ctl_pkg::OFF_DATA_A;
      apb(1, ca, 8'h28); apb(p[0], da, 32'h5a + p);
      #1 chk(dout[p], 0);
      @(posedge clk);
      #1 chk(dout[p], 1);
      apb(!p[0], da, 32'h5a + p);
      #1 chk(dout[p], 1);
    end
    chk(latch_b, 8'h5b);
    chk(latch_a, 8'h5a);
    $display("test pulse done");
    for (int p = 0; p < 2; p++) for (int v = 0; v < 2; v++) begin
      ca = p ? pia_ctl_pkg::OFF_CTRL_B : pia_ctl_pkg::OFF_CTRL_A;
      c = 8'h30 | 8'(v * 8);
      apb(1, ca, c);
      lvl[2 * p + 1] <= 1'b0;
      #1 chk({oe[p], dout[p]}, {1'b1, v[0]});
      pause(6); apb(0, ca, 0); chk(rd, c);
      lvl[2 * p + 1] <= 1'b1;
    end
    $display("test manual done");
    for (int p = 0; p < 2; p++) begin
      ca = p ? pia_ctl_pkg::OFF_CTRL_B : pia_ctl_pkg::OFF_CTRL_A;
      da = p ? pia_ctl_pkg::OFF_DATA_B : pia_ctl_pkg::OFF_DATA_A;
      apb(1, ca, 8'h23);
      auto[p] <= 1'b1;
      pause(8); apb(p[0], da, 0);
      #1 chk(dout[p], 0);
      k = 0;
      while (dout[p] !== 1'b1 && k < 20) begin
        @(posedge clk);
        k++;
      end
      chk(dout[p], 1);
      apb(0, ca, 0); chk(rd, 8'ha3);
      auto[p] <= 1'b0;
      apb(1, ca, 0);
    end
    $display("test handshake done");
    tally_and_finish();
  end
endmodule // pia_control_line_logic_tb
